// ===== hw/slink_dev.sv
// Local design decision: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "slink_cfg.svh"
module slink_dev (
  // Clock and reset
  input  wire logic             sys_clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             master_reset_in,
  // Register port
  slink_if.dev                  bus,
  // Link engine status
  input  wire logic             evt_msg_in,
  input  wire logic             evt_txack_in,
  input  wire logic             evt_attention_flag_in,
  input  wire logic             negative_ack_received_in,
  input  wire logic [2:0]       rx_state_in,
  input  wire logic [6:0]       rx_forward_seq_in,
  input  wire logic             internal_ready_to_send_in,
  input  wire logic             receiver_idle_in,
  input  wire logic             internal_rx_ready_in,
  input  wire logic             cyclic_retx_state_in,
  input  wire logic [1:0]       link_state_in,
  input  wire slink_pkg::byte_t attention_in,
  input  wire logic             tx_forward_indicator_in,
  input  wire logic [6:0]       tx_forward_seq_in,
  input  wire logic             tx_backward_indicator_in,
  input  wire logic [6:0]       tx_backward_seq_in,
  // Engine control
  output logic                  link_enable_out,
  output logic                  host_rx_memory_ready_out,
  output logic                  error_method_select_out,
  output logic                  option_bit_a_out,
  output logic                  option_bit_b_out,
  output logic                  send_out,
  output slink_pkg::byte_t      timer_out,
  output logic [15:0]           buffer_out,
  // Self test
  output logic                  selftest_done_out,
  output logic                  selftest_fail_out,
  // Serial path
  input  wire logic             tx_data_in,
  input  wire logic             tx_clk_in,
  input  wire logic             line_rx_data_in,
  input  wire logic             line_rx_clk_in,
  output logic                  line_tx_data_out,
  output logic                  line_tx_clk_out,
  output logic                  rx_data_out,
  output logic                  rx_clk_out,
  // DMA address
  input  wire logic [15:0]      dma_addr_in,
  input  wire logic             dma_ack_in,
  output logic [15:0]           dma_addr_out,
  output logic                  dma_addr_oe_out
);
  import slink_pkg::*;

  // ************************************************************
  // Storage
  // ************************************************************
  byte_t       ctrl_pri_reg, ctrl_pri_next;
  byte_t       ctrl_sec_reg, ctrl_sec_next;
  byte_t       timer_reg, timer_next;
  byte_t       buf_hi_reg, buf_hi_next;
  byte_t       buf_lo_reg, buf_lo_next;
  byte_t       rx_seq_reg, rx_seq_next;
  logic [3:0]  ev_low_reg, ev_low_next;
  byte_t       link_reg, link_next;
  byte_t       attention_flag_reg, attention_flag_next;
  byte_t       tx_fwd_reg, tx_fwd_next;
  byte_t       tx_bwd_reg, tx_bwd_next;
  byte_t       rd_data_reg, rd_data_next;
  logic [15:0] dma_addr_reg, dma_addr_next;
  logic [2:0]  ev_flags;
  logic        ev_clear;
  logic        in_reset;
  byte_t       events_value;

  // ************************************************************
  // Sticky events
  // ************************************************************
  assign in_reset = ctrl_pri_reg[`CP_RESET];
  assign ev_clear = (bus.rd_en && bus.register_index == `IDX_EVENTS) || in_reset;

  event_flags #(
    .W(3)
  ) u_events (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .set_in     ({evt_msg_in, evt_txack_in, evt_attention_flag_in} & {3{~in_reset}}),
    .clear_in   (ev_clear),
    .flags_out  (ev_flags)
  );

  assign events_value = {ev_flags, ev_low_reg, 1'b0};
  assign bus.irq_n    = ~|ev_flags;

  function automatic byte_t read_mux(input index_t idx);
    case (idx)
      `IDX_CTRL_PRI:   read_mux = ctrl_pri_reg;
      `IDX_CTRL_SEC:   read_mux = ctrl_sec_reg;
      `IDX_RX_SEQ:     read_mux = rx_seq_reg;
      `IDX_EVENTS:     read_mux = events_value;
      `IDX_LINK_STATE: read_mux = link_reg;
      `IDX_ATTENTION:  read_mux = attention_flag_reg;
      `IDX_TX_FWD:     read_mux = tx_fwd_reg;
      `IDX_TX_BWD:     read_mux = tx_bwd_reg;
      `IDX_TIMER:      read_mux = timer_reg;
      `IDX_BUF_HI:     read_mux = buf_hi_reg;
      `IDX_BUF_LO:     read_mux = buf_lo_reg;
      default:         read_mux = 8'h00;
    endcase
  endfunction : read_mux

  // ************************************************************
  // Register file
  // ************************************************************
  always_comb begin
    ctrl_pri_next = ctrl_pri_reg;
    ctrl_sec_next = ctrl_sec_reg;
    timer_next    = timer_reg;
    buf_hi_next   = buf_hi_reg;
    buf_lo_next   = buf_lo_reg;
    if (bus.wr_en) begin
      case (bus.register_index)
        `IDX_CTRL_PRI: ctrl_pri_next = bus.wr_data & `CP_WMASK;
        `IDX_CTRL_SEC: ctrl_sec_next = bus.wr_data & `CS_WMASK;
        `IDX_TIMER:    timer_next    = bus.wr_data;
        `IDX_BUF_HI:   buf_hi_next   = bus.wr_data;
        `IDX_BUF_LO:   buf_lo_next   = bus.wr_data;
        default:       ctrl_sec_next = ctrl_sec_reg;
      endcase
    end
    if (master_reset_in) begin
      ctrl_pri_next[`CP_RESET] = 1'b1;
    end
    if (in_reset) begin
      rx_seq_next = 8'h00;
      ev_low_next = 4'h0;
      link_next   = 8'h00;
      attention_flag_next   = 8'h00;
      tx_fwd_next = 8'hff;
      tx_bwd_next = 8'hff;
    end else begin
      rx_seq_next = {1'b0, rx_forward_seq_in};
      ev_low_next = {negative_ack_received_in, rx_state_in};
      link_next   = {1'b0, internal_ready_to_send_in, receiver_idle_in, internal_rx_ready_in,
                     1'b0, cyclic_retx_state_in, link_state_in};
      attention_flag_next   = attention_in;
      tx_fwd_next = {tx_forward_indicator_in, tx_forward_seq_in};
      tx_bwd_next = {tx_backward_indicator_in, tx_backward_seq_in};
    end
    rd_data_next  = bus.rd_en ? read_mux(bus.register_index) : rd_data_reg;
    dma_addr_next = dma_addr_in;
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_pri_reg <= `CP_RESET_VAL;
      ctrl_sec_reg <= 8'h00;
      timer_reg    <= 8'h00;
      buf_hi_reg   <= 8'h00;
      buf_lo_reg   <= 8'h00;
      rx_seq_reg   <= 8'h00;
      ev_low_reg   <= 4'h0;
      link_reg     <= 8'h00;
      attention_flag_reg     <= 8'h00;
      tx_fwd_reg   <= 8'hff;
      tx_bwd_reg   <= 8'hff;
      rd_data_reg  <= 8'h00;
      dma_addr_reg <= 16'h0000;
    end else begin
      ctrl_pri_reg <= ctrl_pri_next;
      ctrl_sec_reg <= ctrl_sec_next;
      timer_reg    <= timer_next;
      buf_hi_reg   <= buf_hi_next;
      buf_lo_reg   <= buf_lo_next;
      rx_seq_reg   <= rx_seq_next;
      ev_low_reg   <= ev_low_next;
      link_reg     <= link_next;
      attention_flag_reg     <= attention_flag_next;
      tx_fwd_reg   <= tx_fwd_next;
      tx_bwd_reg   <= tx_bwd_next;
      rd_data_reg  <= rd_data_next;
      dma_addr_reg <= dma_addr_next;
    end
  end

  assign bus.rd_data = rd_data_reg;

  // ************************************************************
  // Register self test
  // ************************************************************
  // Alternating patterns catch stuck bits in the scratch cell
  byte_t scratch_reg, scratch_next;
  logic  st_phase_reg, st_phase_next;
  logic  st_done_reg, st_done_next;
  logic  st_fail_reg, st_fail_next;

  always_comb begin
    scratch_next  = scratch_reg;
    st_phase_next = st_phase_reg;
    st_done_next  = st_done_reg;
    st_fail_next  = st_fail_reg;
    if (ctrl_pri_reg[`CP_SELFTEST]) begin
      scratch_next  = st_phase_reg ? `SELFTEST_B : `SELFTEST_A;
      st_phase_next = ~st_phase_reg;
      st_done_next  = st_done_reg | st_phase_reg;
      if (st_done_reg && scratch_reg != (st_phase_reg ? `SELFTEST_A : `SELFTEST_B)) begin
        st_fail_next = 1'b1;
      end
    end else begin
      st_phase_next = 1'b0;
      st_done_next  = 1'b0;
      st_fail_next  = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scratch_reg  <= 8'h00;
      st_phase_reg <= 1'b0;
      st_done_reg  <= 1'b0;
      st_fail_reg  <= 1'b0;
    end else begin
      scratch_reg  <= scratch_next;
      st_phase_reg <= st_phase_next;
      st_done_reg  <= st_done_next;
      st_fail_reg  <= st_fail_next;
    end
  end

  assign selftest_done_out = st_done_reg;
  assign selftest_fail_out = st_fail_reg;

  // ************************************************************
  // Engine control and serial path
  // ************************************************************
  assign link_enable_out          = ~in_reset;
  assign host_rx_memory_ready_out = ctrl_pri_reg[`CP_RX_READY];
  assign error_method_select_out  = ctrl_pri_reg[`CP_METHOD];
  assign option_bit_a_out         = ctrl_sec_reg[`CS_OPT_A];
  assign option_bit_b_out         = ctrl_sec_reg[`CS_OPT_B];
  assign send_out                 = ctrl_sec_reg[`CS_SEND] & ~in_reset;
  assign timer_out                = timer_reg;
  assign buffer_out               = {buf_hi_reg, buf_lo_reg};
  assign line_tx_data_out         = tx_data_in & ~in_reset;
  assign line_tx_clk_out          = tx_clk_in;
  // External receive pins are ignored entirely in loop test
  assign rx_data_out = ~in_reset & (ctrl_pri_reg[`CP_LOOP] ? tx_data_in : line_rx_data_in);
  assign rx_clk_out  = ctrl_pri_reg[`CP_LOOP] ? tx_clk_in : line_rx_clk_in;

  // ************************************************************
  // DMA address drive
  // ************************************************************
  assign dma_addr_out    = dma_addr_reg;
  assign dma_addr_oe_out = ctrl_sec_reg[`CS_ADDRESS_DRIVE_SELECT] | ~dma_ack_in;
endmodule : slink_dev
`default_nettype wire

// ===== include/slink_cfg.svh
`ifndef SLINK_CFG_SVH
`define SLINK_CFG_SVH
// ************************************************************
// Register indices
// ************************************************************
`define IDX_CTRL_PRI   4'h0
`define IDX_CTRL_SEC   4'h1
`define IDX_RX_SEQ     4'h2
`define IDX_EVENTS     4'h3
`define IDX_LINK_STATE 4'h4
`define IDX_ATTENTION  4'h5
`define IDX_TX_FWD     4'h6
`define IDX_TX_BWD     4'h7
`define IDX_TIMER      4'h8
`define IDX_BUF_HI     4'ha
`define IDX_BUF_LO     4'hb
// ************************************************************
// Field positions, masks, reset values
// ************************************************************
`define CP_RESET       0
`define CP_RX_READY    1
`define CP_SELFTEST    2
`define CP_LOOP        3
`define CP_METHOD      7
`define CS_SEND        0
`define CS_OPT_A       1
`define CS_OPT_B       2
`define CS_ADDRESS_DRIVE_SELECT        4
`define CP_WMASK       8'h8f
`define CS_WMASK       8'h17
`define CP_RESET_VAL   8'h01
`define EV_MSG         7
`define LS_IRX_READY   4
`define EVENTS_RMASK   8'hfe
`define RX_SEQ_RMASK   8'h7f
`define LINK_RMASK     8'h77
`define SELFTEST_A     8'h55
`define SELFTEST_B     8'haa
// ************************************************************
// Host APB map
// ************************************************************
`define APB_CMD        12'h000
`define APB_STATUS     12'h004
`define APB_CONFIG     12'h008
`define CMD_WRITE      16
`define CMD_READ       17
`endif

// ===== include/slink_pkg.sv
`default_nettype none
package slink_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [3:0] index_t;
  typedef enum logic [1:0] {H_IDLE, H_ACCESS, H_CAPTURE} host_state_e;
endpackage : slink_pkg
`default_nettype wire

// ===== include/slink_if.sv
`timescale 1ns/1ps
`default_nettype none
interface slink_if;
  slink_pkg::index_t register_index;
  slink_pkg::byte_t  wr_data;
  logic              wr_en;
  logic              rd_en;
  slink_pkg::byte_t  rd_data;
  logic              irq_n;
  modport dev (
    input  register_index, wr_data, wr_en, rd_en,
    output rd_data, irq_n
  );
  modport host (
    output register_index, wr_data, wr_en, rd_en,
    input  rd_data, irq_n
  );
endinterface : slink_if
`default_nettype wire

// ===== hw/event_flags.sv
`timescale 1ns/1ps
`default_nettype none
module event_flags #(
  parameter int W = 3
) (
  // Clock and reset
  input  wire logic         sys_clk_in,
  input  wire logic         rst_n_in,
  // Control
  input  wire logic [W-1:0] set_in,
  input  wire logic         clear_in,
  // Flags
  output logic      [W-1:0] flags_out
);
  logic [W-1:0] flags_reg;
  logic [W-1:0] flags_next;

  // A set in the clearing cycle survives
  always_comb begin
    flags_next = (flags_reg & ~{W{clear_in}}) | set_in;
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign flags_out = flags_reg;
endmodule : event_flags
`default_nettype wire

// ===== hw/slink_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "slink_cfg.svh"
module slink_host (
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Device side
  slink_if.host            bus
);
  import slink_pkg::*;

  host_state_e state_reg, state_next;
  index_t      idx_reg, idx_next;
  byte_t       wdata_reg, wdata_next;
  logic        op_wr_reg, op_wr_next;
  byte_t       rdata_reg, rdata_next;
  byte_t       shadow_reg, shadow_next;
  logic        refused_reg, refused_next;
  logic        auto_reg, auto_next;
  logic        apb_wr;
  logic        apb_rd;

  function automatic byte_t write_mask(input index_t idx, input byte_t d);
    case (idx)
      `IDX_CTRL_PRI: write_mask = d & `CP_WMASK;
      `IDX_CTRL_SEC: write_mask = d & `CS_WMASK;
      default:       write_mask = d;
    endcase
  endfunction : write_mask

  function automatic byte_t read_mask(input index_t idx, input byte_t d);
    case (idx)
      `IDX_RX_SEQ:     read_mask = d & `RX_SEQ_RMASK;
      `IDX_EVENTS:     read_mask = d & `EVENTS_RMASK;
      `IDX_LINK_STATE: read_mask = d & `LINK_RMASK;
      default:         read_mask = d;
    endcase
  endfunction : read_mask

  assign apb_wr  = psel && penable && pwrite;
  assign apb_rd  = psel && penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && paddr != `APB_CMD && paddr != `APB_STATUS && paddr != `APB_CONFIG;

  // ************************************************************
  // Command sequencer
  // ************************************************************
  always_comb begin
    state_next   = state_reg;
    idx_next     = idx_reg;
    wdata_next   = wdata_reg;
    op_wr_next   = op_wr_reg;
    rdata_next   = rdata_reg;
    shadow_next  = shadow_reg;
    refused_next = refused_reg;
    auto_next    = auto_reg;
    if (apb_wr && paddr == `APB_STATUS && pwdata[2]) begin
      refused_next = 1'b0;
    end
    if (apb_wr && paddr == `APB_CONFIG) begin
      auto_next = pwdata[0];
    end
    case (state_reg)
      H_IDLE: begin
        if (apb_wr && paddr == `APB_CMD && (pwdata[`CMD_WRITE] || pwdata[`CMD_READ])) begin
          idx_next   = pwdata[3:0];
          wdata_next = write_mask(pwdata[3:0], pwdata[15:8]);
          op_wr_next = pwdata[`CMD_WRITE];
          if (pwdata[`CMD_WRITE] && pwdata[3:0] >= `IDX_RX_SEQ && pwdata[3:0] <= `IDX_TX_BWD) begin
            refused_next = 1'b1;
          end else begin
            state_next = H_ACCESS;
          end
        end
      end
      H_ACCESS: begin
        if (op_wr_reg) begin
          state_next = H_IDLE;
          if (idx_reg == `IDX_CTRL_PRI) begin
            shadow_next = wdata_reg;
          end
        end else begin
          state_next = H_CAPTURE;
        end
      end
      H_CAPTURE: begin
        rdata_next = read_mask(idx_reg, bus.rd_data);
        state_next = H_IDLE;
        // Receiver-ready handed back once the device or a message shows it
        if (auto_reg && shadow_reg[`CP_RX_READY] &&
            ((idx_reg == `IDX_EVENTS && bus.rd_data[`EV_MSG]) ||
             (idx_reg == `IDX_LINK_STATE && bus.rd_data[`LS_IRX_READY]))) begin
          idx_next   = `IDX_CTRL_PRI;
          wdata_next = shadow_reg & ~(8'h01 << `CP_RX_READY);
          op_wr_next = 1'b1;
          state_next = H_ACCESS;
        end
      end
      default: state_next = H_IDLE;
    endcase
    if (apb_wr && paddr == `APB_CMD && state_reg != H_IDLE) begin
      refused_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg   <= H_IDLE;
      idx_reg     <= 4'h0;
      wdata_reg   <= 8'h00;
      op_wr_reg   <= 1'b0;
      rdata_reg   <= 8'h00;
      shadow_reg  <= `CP_RESET_VAL;
      refused_reg <= 1'b0;
      auto_reg    <= 1'b0;
    end else begin
      state_reg   <= state_next;
      idx_reg     <= idx_next;
      wdata_reg   <= wdata_next;
      op_wr_reg   <= op_wr_next;
      rdata_reg   <= rdata_next;
      shadow_reg  <= shadow_next;
      refused_reg <= refused_next;
      auto_reg    <= auto_next;
    end
  end

  assign bus.register_index = idx_reg;
  assign bus.wr_data        = wdata_reg;
  assign bus.wr_en          = state_reg == H_ACCESS && op_wr_reg;
  assign bus.rd_en          = state_reg == H_ACCESS && !op_wr_reg;

  // ************************************************************
  // APB read data
  // ************************************************************
  always_comb begin
    prdata = 32'h0000_0000;
    if (apb_rd) begin
      case (paddr)
        `APB_CMD:    prdata = {14'h0000, 2'b00, wdata_reg, 4'h0, idx_reg};
        `APB_STATUS: prdata = {16'h0000, rdata_reg, 5'h00, refused_reg, ~bus.irq_n, state_reg != H_IDLE};
        `APB_CONFIG: prdata = {31'h0000_0000, auto_reg};
        default:     prdata = 32'h0000_0000;
      endcase
    end
  end
endmodule : slink_host
`default_nettype wire

// ===== tb/slink_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "slink_cfg.svh"
module slink_assertions (
  // Clock and reset
  input wire logic              sys_clk_in,
  input wire logic              rst_n_in,
  // Register port
  input wire slink_pkg::index_t register_index,
  input wire slink_pkg::byte_t  wr_data,
  input wire logic              wr_en,
  input wire logic              rd_en,
  input wire slink_pkg::byte_t  rd_data,
  input wire logic              irq_n
);
  import slink_pkg::*;
  logic rst_bit_reg;
  logic rst_bit_next;
  // Host writes only; a master reset goes unseen, which only narrows the checks
  always_comb begin
    rst_bit_next = rst_bit_reg;
    if (wr_en && register_index == `IDX_CTRL_PRI) begin
      rst_bit_next = wr_data[`CP_RESET];
    end
  end
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_bit_reg <= 1'b1;
    end else begin
      rst_bit_reg <= rst_bit_next;
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // ************************************************************
  // Register port checks
  // ************************************************************
  irq_read_a: assert property (rd_en && register_index == `IDX_EVENTS |=>
    (rd_data[7:5] != 3'b000) == !$past(irq_n)) else $error("interrupt level disagrees with event bits");
  events_rsvd_a: assert property (rd_en && register_index == `IDX_EVENTS |=> !rd_data[0])
    else $error("event register spare bit not zero");
  fwd_rsvd_a: assert property (rd_en && register_index == `IDX_RX_SEQ |=> !rd_data[7])
    else $error("sequence register spare bit not zero");
  link_rsvd_a: assert property (rd_en && register_index == `IDX_LINK_STATE |=>
    rd_data[7] == 1'b0 && rd_data[3] == 1'b0) else $error("link state spare bits not zero");
  unused_idx_a: assert property (rd_en && (register_index == 4'h9 || register_index >= 4'hc)
    |=> rd_data == 8'h00) else $error("unused index read not zero");
  no_status_wr_a: assert property (wr_en |-> !(register_index inside {[4'h2:4'h7]}))
    else $error("write issued to status register");
  strobe_pulse_a: assert property ((wr_en || rd_en) |=> !wr_en && !rd_en)
    else $error("strobe longer than one cycle");
  rd_hold_a: assert property (!rd_en |=> $stable(rd_data))
    else $error("read data changed without read");
  rst_ones_a: assert property (rst_bit_reg && rd_en && register_index inside {4'h6, 4'h7}
    |=> rd_data == 8'hff) else $error("transmit status not all ones in reset");
  rst_zero_a: assert property (rst_bit_reg && rd_en && register_index inside {[4'h2:4'h5]}
    |=> rd_data == 8'h00) else $error("status not zero in reset");
  cover property (rd_en && register_index == `IDX_EVENTS && !irq_n);
  cover property (wr_en && register_index == `IDX_CTRL_PRI);
  cover property (rd_en && rst_bit_reg && register_index == `IDX_TX_FWD);
endmodule : slink_assertions
`default_nettype wire

// ===== tb/test_signalling_link_ctrl_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "slink_cfg.svh"
module test_signalling_link_ctrl_regs;
  import slink_pkg::*;
  logic        sys_clk_in, rst_n_in, psel, penable, pwrite, pready, pslverr, err;
  logic        mr, dack, td, ld, link_en, rxmem, meth, opa, opb, send, st_done, st_fail;
  logic        ltd, rxd, oe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [2:0]  ev;
  logic [15:0] buf16;
  byte_t       sv, r, tmr;
  byte_t       msk [6] = '{8'h7f, 8'h1e, 8'h77, 8'hff, 8'hff, 8'hff};
  index_t      nu [5] = '{4'h9, 4'hc, 4'hd, 4'he, 4'hf};
  int          num_errors, n_compared;
  slink_if sif ();
  slink_host u_slink_host (.sys_clk_in, .rst_n_in, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .bus(sif));
  slink_dev u_slink_dev (.sys_clk_in, .rst_n_in, .master_reset_in(mr), .bus(sif), .evt_msg_in(ev[2]),
    .evt_txack_in(ev[1]), .evt_attention_flag_in(ev[0]), .negative_ack_received_in(sv[4]), .rx_state_in(sv[3:1]),
    .rx_forward_seq_in(sv[6:0]), .internal_ready_to_send_in(sv[6]), .receiver_idle_in(sv[5]),
    .internal_rx_ready_in(sv[4]), .cyclic_retx_state_in(sv[2]), .link_state_in(sv[1:0]), .attention_in(sv),
    .tx_forward_indicator_in(sv[7]), .tx_forward_seq_in(sv[6:0]), .tx_backward_indicator_in(sv[7]),
    .tx_backward_seq_in(sv[6:0]), .link_enable_out(link_en), .host_rx_memory_ready_out(rxmem),
    .error_method_select_out(meth), .option_bit_a_out(opa), .option_bit_b_out(opb), .send_out(send),
    .timer_out(tmr), .buffer_out(buf16), .selftest_done_out(st_done), .selftest_fail_out(st_fail),
    .tx_data_in(td), .tx_clk_in(1'b0), .line_rx_data_in(ld), .line_rx_clk_in(1'b0),
    .line_tx_data_out(ltd), .line_tx_clk_out(), .rx_data_out(rxd), .rx_clk_out(),
    .dma_addr_in(16'h1234), .dma_ack_in(dack), .dma_addr_out(), .dma_addr_oe_out(oe));
  slink_assertions u_slink_assertions (.sys_clk_in, .rst_n_in, .register_index(sif.register_index),
    .wr_data(sif.wr_data), .wr_en(sif.wr_en), .rd_en(sif.rd_en), .rd_data(sif.rd_data), .irq_n(sif.irq_n));
  // ************************************************************
  // Bus tasks
  // ************************************************************
  task chk(input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (e !== g) begin
      num_errors++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk_in);
    penable <= 1'b1;
    do @(posedge sys_clk_in); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk_in);
  endtask : apb
  // Poll until idle; a stuck busy flag is left to the watchdog
  task dev(input logic w, input index_t i, input byte_t d);
    apb(1'b1, `APB_CMD, {14'h0000, !w, w, d, 4'h0, i});
    do apb(1'b0, `APB_STATUS, 32'h0000_0000);
    while (q[0]);
    r = q[15:8];
  endtask : dev
  task rd(input index_t i, input byte_t e);
    dev(1'b0, i, 8'h00);
    chk(e, r);
  endtask : rd
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  initial begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    #(20 * 20000);
    num_errors++;
    test_done();
  end
  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    {rst_n_in, psel, penable, pwrite, mr, ld, ev, paddr, pwdata} = '0;
    {dack, td, sv, num_errors, n_compared} = {1'b1, 1'b1, 8'ha5, 64'h0};
    repeat (3) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    @(posedge sys_clk_in);
    chk(1'b0, link_en);
    chk(1'b0, ltd);
    rd(`IDX_TX_FWD, 8'hff);
    rd(`IDX_TX_BWD, 8'hff);
    rd(`IDX_RX_SEQ, 8'h00);
    rd(`IDX_ATTENTION, 8'h00);
    $display("reset test done");
    dev(1'b1, `IDX_CTRL_PRI, 8'h02);
    chk(3'b111, {link_en, ltd, rxmem});
    chk(1'b0, rxd);
    for (int p = 0; p < 2; p++) begin
      sv <= p ? 8'h5a : 8'ha5;
      @(posedge sys_clk_in);
      for (int i = 2; i < 8; i++) rd(index_t'(i), sv & msk[i-2]);
    end
    foreach (nu[k]) rd(nu[k], 8'h00);
    $display("status test done");
    dev(1'b1, `IDX_TIMER, 8'h3c);
    dev(1'b1, `IDX_BUF_HI, 8'hc3);
    dev(1'b1, `IDX_BUF_LO, 8'h96);
    rd(`IDX_TIMER, 8'h3c);
    chk({8'h3c, 16'hc396}, {tmr, buf16});
    dev(1'b1, `IDX_TX_FWD, 8'h00);
    chk(1'b1, q[2]);
    rd(`IDX_TX_FWD, sv);
    apb(1'b1, `APB_STATUS, 32'h0000_0004);
    apb(1'b0, 12'h00c, 32'h0000_0000);
    chk(1'b1, err);
    $display("access test done");
    for (int i = 0; i < 3; i++) begin
      ev <= 3'b001 << i;
      @(posedge sys_clk_in);
      ev <= 3'b000;
      @(posedge sys_clk_in);
      chk(1'b0, sif.irq_n);
      rd(`IDX_EVENTS, (8'h20 << i) | (sv & 8'h1e));
      chk(1'b1, sif.irq_n);
      rd(`IDX_EVENTS, sv & 8'h1e);
    end
    apb(1'b1, `APB_CONFIG, 32'h0000_0001);
    ev <= 3'b100;
    @(posedge sys_clk_in);
    ev <= 3'b000;
    @(posedge sys_clk_in);
    apb(1'b0, `APB_STATUS, 32'h0000_0000);
    chk(1'b1, q[1]);
    rd(`IDX_EVENTS, 8'h80 | (sv & 8'h1e));
    chk(1'b0, rxmem);
    apb(1'b1, `APB_CONFIG, 32'h0000_0000);
    $display("event test done");
    dev(1'b1, `IDX_CTRL_SEC, 8'h17);
    rd(`IDX_CTRL_SEC, 8'h17);
    chk(4'hf, {send, opb, opa, oe});
    dev(1'b1, `IDX_CTRL_SEC, 8'h00);
    chk(1'b0, oe);
    dack <= 1'b0;
    @(posedge sys_clk_in);
    @(posedge sys_clk_in);
    chk(1'b1, oe);
    dev(1'b1, `IDX_CTRL_PRI, 8'h08);
    chk(1'b1, rxd);
    dev(1'b1, `IDX_CTRL_PRI, 8'h84);
    rd(`IDX_CTRL_PRI, 8'h84);
    chk(3'b101, {st_done, st_fail, meth});
    $display("control test done");
    mr <= 1'b1;
    @(posedge sys_clk_in);
    mr <= 1'b0;
    @(posedge sys_clk_in);
    @(posedge sys_clk_in);
    chk(1'b0, link_en);
    rd(`IDX_TX_BWD, 8'hff);
    $display("master reset test done");
    test_done();
  end
endmodule : test_signalling_link_ctrl_regs
`default_nettype wire
